// ---- exposure_trigger_pkg.sv ----
package exposure_trigger_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned US_NS           = 1000;
  localparam int unsigned CYC_PER_US      = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  US_TICK_LAST    = 4'(CYC_PER_US - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  EXP_RAW_OFS     = 8'h04;
  localparam logic [7:0]  EXP_BASE_OFS    = 8'h08;
  localparam logic [7:0]  EXP_ABS_OFS     = 8'h0c;
  localparam logic [7:0]  FRAME_PER_OFS   = 8'h10;
  localparam logic [7:0]  CMD_OFS         = 8'h14;
  localparam logic [7:0]  STATUS_OFS      = 8'h18;

  ////////////////////////////////////////////////////////////////////////////////
  // control, command and status field positions
  localparam int unsigned CTRL_LEGACY     = 0;
  localparam int unsigned CTRL_CONT       = 1;
  localparam int unsigned CTRL_AS_ON      = 2;
  localparam int unsigned CTRL_AS_LINE    = 3;
  localparam int unsigned CTRL_AS_FALL    = 4;
  localparam int unsigned CTRL_FS_ON      = 5;
  localparam int unsigned CTRL_FS_LINE    = 6;
  localparam int unsigned CTRL_FS_FALL    = 7;
  localparam int unsigned CTRL_RATE_EN    = 8;
  localparam int unsigned CTRL_W          = 9;
  localparam int unsigned CMD_START       = 0;
  localparam int unsigned CMD_STOP        = 1;
  localparam int unsigned CMD_AS_SW       = 2;
  localparam int unsigned CMD_FS_SW       = 3;
  localparam int unsigned STAT_CNT_LSB    = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // widths, limits and reset values
  localparam int unsigned RAW_W           = 12;
  localparam int unsigned BASE_W          = 24;
  localparam logic [11:0] RAW_MIN         = 12'h001;
  localparam logic [11:0] RAW_MAX         = 12'hfff;
  localparam logic [8:0]  CTRL_RESET      = 9'h103;
  localparam logic [11:0] RAW_RESET       = 12'h001;
  localparam logic [23:0] BASE_RESET      = 24'h00_0014;
  localparam logic [31:0] FRAME_PER_RESET = 32'h0000_2710;
  localparam logic [5:0]  DIV_STEPS       = 6'h21;

  typedef enum logic [1:0] {
    ACQ_IDLE,
    ACQ_WAIT_AS,
    ACQ_WAIT_FS,
    ACQ_EXPOSE
  } acq_state_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_out_t;

  typedef struct packed {
    logic exposure_active;
    logic frame_start_pulse;
    logic wait_acq_start;
    logic wait_frame_start;
  } acq_out_t;

  typedef struct packed {
    apb_out_t          bus;
    acq_out_t          acq;
    logic [CTRL_W-1:0] ctrl;
    logic [11:0]       raw;
    logic [23:0]       base;
    logic [31:0]       abs_us;
    logic [31:0]       period_us;
    logic              div_busy;
    logic [5:0]        div_cnt;
    logic [32:0]       div_num;
    logic [32:0]       div_rem;
    logic [32:0]       div_quo;
    logic [3:0]        us_cnt;
    logic              us_tick;
    logic              line_s1;
    logic              line_s2;
    logic              line_s3;
    acq_state_t        st;
    logic [31:0]       exp_left;
    logic [31:0]       since_us;
    logic [15:0]       frames;
  } state_t;

endpackage

// ---- exposure_trigger.sv ----
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
module exposure_trigger (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        trigger_line,
  output logic             exposure_active,
  output logic             frame_start_pulse,
  output logic             wait_acq_start,
  output logic             wait_frame_start
);

  exposure_trigger_pkg::state_t s_reg;
  exposure_trigger_pkg::state_t s_next;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [11:0] clamp_raw(input logic [32:0] v);
    if (v < 33'(exposure_trigger_pkg::RAW_MIN)) begin
      clamp_raw = exposure_trigger_pkg::RAW_MIN;
    end else if (v > 33'(exposure_trigger_pkg::RAW_MAX)) begin
      clamp_raw = exposure_trigger_pkg::RAW_MAX;
    end else begin
      clamp_raw = v[11:0];
    end
  endfunction

  function automatic logic [31:0] mul_sat(input logic [11:0] r, input logic [23:0] b);
    logic [35:0] p;
    p = 36'(r) * 36'(b);
    if (p[35:32] != 4'h0) begin
      mul_sat = 32'hffff_ffff;
    end else begin
      mul_sat = p[31:0];
    end
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == exposure_trigger_pkg::CTRL_OFS) || (a == exposure_trigger_pkg::EXP_RAW_OFS) ||
                (a == exposure_trigger_pkg::EXP_BASE_OFS) || (a == exposure_trigger_pkg::EXP_ABS_OFS) ||
                (a == exposure_trigger_pkg::FRAME_PER_OFS) || (a == exposure_trigger_pkg::CMD_OFS) ||
                (a == exposure_trigger_pkg::STATUS_OFS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  logic        setup;
  logic        access;
  logic [32:0] rem_sh;
  logic        cmd_start;
  logic        cmd_stop;
  logic        sw_as;
  logic        sw_fs;
  logic        rise;
  logic        fall;
  logic        fs_on;
  logic        fs_line;
  logic        fs_fall;
  logic        as_internal;
  logic        as_evt;
  logic        fs_ext_evt;
  logic        pace_ok;
  logic [11:0] new_raw;

  always_comb begin
    s_next      = s_reg;
    setup       = psel && !penable;
    access      = psel && penable && s_reg.bus.pready;
    rem_sh      = '0;
    new_raw     = '0;
    cmd_start   = 1'b0;
    cmd_stop    = 1'b0;
    sw_as       = 1'b0;
    sw_fs       = 1'b0;

    // microsecond enable
    s_next.us_tick = 1'b0;
    if (s_reg.us_cnt == exposure_trigger_pkg::US_TICK_LAST) begin
      s_next.us_cnt  = 4'h0;
      s_next.us_tick = 1'b1;
    end else begin
      s_next.us_cnt = s_reg.us_cnt + 4'h1;
    end

    // trigger line synchroniser and edge detect
    s_next.line_s1 = trigger_line;
    s_next.line_s2 = s_reg.line_s1;
    s_next.line_s3 = s_reg.line_s2;
    rise = s_reg.line_s2 && !s_reg.line_s3;
    fall = !s_reg.line_s2 && s_reg.line_s3;

    // rounding divider: (abs + base/2) / base
    // quotient is complete in the cycle that ready stands
    if (s_reg.div_busy) begin
      rem_sh         = {s_reg.div_rem[31:0], s_reg.div_num[32]};
      s_next.div_num = {s_reg.div_num[31:0], 1'b0};
      if (rem_sh >= 33'(s_reg.base)) begin
        s_next.div_rem = rem_sh - 33'(s_reg.base);
        s_next.div_quo = {s_reg.div_quo[31:0], 1'b1};
      end else begin
        s_next.div_rem = rem_sh;
        s_next.div_quo = {s_reg.div_quo[31:0], 1'b0};
      end
      s_next.div_cnt = s_reg.div_cnt - 6'h01;
      if (s_reg.div_cnt == 6'h01) begin
        s_next.div_busy   = 1'b0;
        s_next.bus.pready = 1'b1;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb setup phase
    if (setup) begin
      s_next.bus.pslverr = !is_mapped(paddr);
      s_next.bus.prdata  = 32'h0000_0000;
      s_next.bus.pready  = 1'b1;
      if (pwrite && paddr == exposure_trigger_pkg::EXP_ABS_OFS) begin
        s_next.bus.pready = 1'b0;
        s_next.div_busy   = 1'b1;
        s_next.div_cnt    = exposure_trigger_pkg::DIV_STEPS;
        s_next.div_num    = 33'(pwdata) + 33'(s_reg.base[23:1]);
        s_next.div_rem    = '0;
        s_next.div_quo    = '0;
      end
      if (!pwrite) begin
        unique case (paddr)
          exposure_trigger_pkg::CTRL_OFS:      s_next.bus.prdata = 32'(s_reg.ctrl);
          exposure_trigger_pkg::EXP_RAW_OFS:   s_next.bus.prdata = 32'(s_reg.raw);
          exposure_trigger_pkg::EXP_BASE_OFS:  s_next.bus.prdata = 32'(s_reg.base);
          exposure_trigger_pkg::EXP_ABS_OFS:   s_next.bus.prdata = s_reg.abs_us;
          exposure_trigger_pkg::FRAME_PER_OFS: s_next.bus.prdata = s_reg.period_us;
          exposure_trigger_pkg::STATUS_OFS:    s_next.bus.prdata = {s_reg.frames, 12'h000, s_reg.acq.exposure_active,
                                                 s_reg.st != exposure_trigger_pkg::ACQ_IDLE,
                                                 s_reg.acq.wait_frame_start, s_reg.acq.wait_acq_start};
          default:                             s_next.bus.prdata = 32'h0000_0000;
        endcase
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb access phase, write commits here
    if (access) begin
      s_next.bus.pready = 1'b0;
      // error flag and read data stand only with their own ready
      s_next.bus.pslverr = 1'b0;
      s_next.bus.prdata  = 32'h0000_0000;
      if (pwrite) begin
        unique case (paddr)
          exposure_trigger_pkg::CTRL_OFS: begin
            s_next.ctrl = pwdata[exposure_trigger_pkg::CTRL_W-1:0];
          end
          exposure_trigger_pkg::EXP_RAW_OFS: begin
            new_raw       = clamp_raw(33'(pwdata));
            s_next.raw    = new_raw;
            s_next.abs_us = mul_sat(new_raw, s_reg.base);
          end
          exposure_trigger_pkg::EXP_BASE_OFS: begin
            s_next.base   = (pwdata[23:0] == 24'h00_0000) ? 24'h00_0001 : pwdata[23:0];
            s_next.abs_us = mul_sat(s_reg.raw, s_next.base);
          end
          exposure_trigger_pkg::EXP_ABS_OFS: begin
            new_raw       = clamp_raw(s_reg.div_quo);
            s_next.raw    = new_raw;
            s_next.abs_us = mul_sat(new_raw, s_reg.base);
          end
          exposure_trigger_pkg::FRAME_PER_OFS: begin
            s_next.period_us = pwdata;
          end
          exposure_trigger_pkg::CMD_OFS: begin
            cmd_start = pwdata[exposure_trigger_pkg::CMD_START];
            cmd_stop  = pwdata[exposure_trigger_pkg::CMD_STOP];
            sw_as     = pwdata[exposure_trigger_pkg::CMD_AS_SW];
            sw_fs     = pwdata[exposure_trigger_pkg::CMD_FS_SW];
          end
          default: begin
          end
        endcase
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trigger selection
    if (s_reg.ctrl[exposure_trigger_pkg::CTRL_LEGACY]) begin
      fs_on   = s_reg.ctrl[exposure_trigger_pkg::CTRL_AS_ON];
      fs_line = s_reg.ctrl[exposure_trigger_pkg::CTRL_AS_LINE];
      fs_fall = s_reg.ctrl[exposure_trigger_pkg::CTRL_AS_FALL];
      sw_fs   = sw_fs || sw_as;
      as_internal = 1'b1;
    end else begin
      fs_on   = s_reg.ctrl[exposure_trigger_pkg::CTRL_FS_ON];
      fs_line = s_reg.ctrl[exposure_trigger_pkg::CTRL_FS_LINE];
      fs_fall = s_reg.ctrl[exposure_trigger_pkg::CTRL_FS_FALL];
      as_internal = !s_reg.ctrl[exposure_trigger_pkg::CTRL_AS_ON];
    end
    as_evt = s_reg.ctrl[exposure_trigger_pkg::CTRL_AS_LINE] ?
             (s_reg.ctrl[exposure_trigger_pkg::CTRL_AS_FALL] ? fall : rise) : sw_as;
    fs_ext_evt = fs_line ? (fs_fall ? fall : rise) : sw_fs;
    pace_ok = !s_reg.ctrl[exposure_trigger_pkg::CTRL_RATE_EN] || (s_reg.since_us >= s_reg.period_us);

    if (s_reg.us_tick && s_reg.since_us != 32'hffff_ffff) begin
      s_next.since_us = s_reg.since_us + 32'h0000_0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // acquisition sequencer
    s_next.acq.frame_start_pulse = 1'b0;
    unique case (s_reg.st)
      exposure_trigger_pkg::ACQ_IDLE: begin
        if (cmd_start) begin
          s_next.st = as_internal ? exposure_trigger_pkg::ACQ_WAIT_FS : exposure_trigger_pkg::ACQ_WAIT_AS;
        end
      end
      exposure_trigger_pkg::ACQ_WAIT_AS: begin
        if (as_evt) begin
          s_next.st = exposure_trigger_pkg::ACQ_WAIT_FS;
        end
      end
      exposure_trigger_pkg::ACQ_WAIT_FS: begin
        if (fs_on ? fs_ext_evt : pace_ok) begin
          s_next.st                    = exposure_trigger_pkg::ACQ_EXPOSE;
          s_next.exp_left              = s_reg.abs_us;
          s_next.since_us              = 32'h0000_0000;
          s_next.frames                = s_reg.frames + 16'h0001;
          s_next.acq.frame_start_pulse = 1'b1;
        end
      end
      exposure_trigger_pkg::ACQ_EXPOSE: begin
        if (s_reg.us_tick) begin
          s_next.exp_left = s_reg.exp_left - 32'h0000_0001;
          if (s_reg.exp_left <= 32'h0000_0001) begin
            if (!s_reg.ctrl[exposure_trigger_pkg::CTRL_CONT]) begin
              s_next.st = exposure_trigger_pkg::ACQ_IDLE;
            end else begin
              s_next.st = as_internal ? exposure_trigger_pkg::ACQ_WAIT_FS : exposure_trigger_pkg::ACQ_WAIT_AS;
            end
          end
        end
      end
    endcase
    // stop wins over any transition
    if (cmd_stop) begin
      s_next.st = exposure_trigger_pkg::ACQ_IDLE;
    end
    s_next.acq.exposure_active  = (s_next.st == exposure_trigger_pkg::ACQ_EXPOSE);
    s_next.acq.wait_acq_start   = (s_next.st == exposure_trigger_pkg::ACQ_WAIT_AS);
    s_next.acq.wait_frame_start = (s_next.st == exposure_trigger_pkg::ACQ_WAIT_FS);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg           <= '0;
      s_reg.st        <= exposure_trigger_pkg::ACQ_IDLE;
      s_reg.ctrl      <= exposure_trigger_pkg::CTRL_RESET;
      s_reg.raw       <= exposure_trigger_pkg::RAW_RESET;
      s_reg.base      <= exposure_trigger_pkg::BASE_RESET;
      s_reg.abs_us    <= 32'(exposure_trigger_pkg::BASE_RESET);
      s_reg.period_us <= exposure_trigger_pkg::FRAME_PER_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign pready            = s_reg.bus.pready;
  assign prdata            = s_reg.bus.prdata;
  assign pslverr           = s_reg.bus.pslverr;
  assign exposure_active   = s_reg.acq.exposure_active;
  assign frame_start_pulse = s_reg.acq.frame_start_pulse;
  assign wait_acq_start    = s_reg.acq.wait_acq_start;
  assign wait_frame_start  = s_reg.acq.wait_frame_start;

endmodule

// ---- trigger_sensor_model.sv ----
`timescale 1ns/1ps
module trigger_sensor_model (
  input  wire logic pclk,
  input  wire logic fire,
  output logic      trigger_line
);
  // one clean high pulse per requested frame, low while idle
  logic [3:0] hold_reg = 4'h0;
  always @(posedge pclk) begin
    if (fire) begin
      hold_reg <= 4'h6;
    end else if (hold_reg != 4'h0) begin
      hold_reg <= hold_reg - 4'h1;
    end
  end
  assign trigger_line = (hold_reg != 4'h0);
endmodule

// ---- exposure_trigger_checker.sv ----
`timescale 1ns/1ps
module exposure_trigger_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        trigger_line,
  input wire logic        exposure_active,
  input wire logic        frame_start_pulse,
  input wire logic        wait_acq_start,
  input wire logic        wait_frame_start
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence abs_wr_s;
    psel && !penable && pwrite && paddr == exposure_trigger_pkg::EXP_ABS_OFS;
  endsequence
  chk_abs_wr_wait: assert property (abs_wr_s |=> (!pready)[*8] ##26 pready)
    else $error("absolute write ready timing wrong");
  chk_zero_wait: assert property (setup_s ##0 !(pwrite && paddr == exposure_trigger_pkg::EXP_ABS_OFS) |=> pready)
    else $error("plain access not zero wait");
  chk_setup_low: assert property (setup_s |-> !pready)
    else $error("ready high in setup");
  chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error without ready or with data");
  chk_start_pulse: assert property ($rose(exposure_active) |-> frame_start_pulse)
    else $error("exposure began without frame start");
  chk_pulse_single: assert property (frame_start_pulse |=> !frame_start_pulse)
    else $error("frame start longer than one cycle");
  chk_pulse_waiting: assert property (frame_start_pulse |-> $past(wait_frame_start) || $past(wait_frame_start, 2))
    else $error("frame start outside waiting state");
  chk_min_expose: assert property ($rose(exposure_active) |-> exposure_active[*8])
    else $error("exposure too short");
  chk_waits_excl: assert property (!(wait_acq_start && wait_frame_start))
    else $error("both wait states at once");
endmodule
bind exposure_trigger exposure_trigger_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .trigger_line(trigger_line), .exposure_active(exposure_active), .frame_start_pulse(frame_start_pulse),
  .wait_acq_start(wait_acq_start), .wait_frame_start(wait_frame_start));

// ---- test_exposure_trigger.sv ----
`timescale 1ns/1ps
module test_exposure_trigger;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        fire = 1'b0;
  logic        trigger_line;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        exposure_active;
  logic        frame_start_pulse;
  logic        wait_acq_start;
  logic        wait_frame_start;
  int          n_fail = 0;
  int          checks_done = 0;
  always #50 pclk = ~pclk;
  exposure_trigger dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .trigger_line(trigger_line), .exposure_active(exposure_active), .frame_start_pulse(frame_start_pulse),
    .wait_acq_start(wait_acq_start), .wait_frame_start(wait_frame_start));
  trigger_sensor_model sensor (.pclk(pclk), .fire(fire), .trigger_line(trigger_line));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_rng(input string name, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("mismatch %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  task automatic timeout();
    n_fail++;
    $display("mismatch wait expected done seen timeout");
    end_sim();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 100);
    if (pready !== 1'b1) timeout();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(name, exp, r);
  endtask
  task automatic wait_pulse(output int t);
    t = 0;
    do begin
      @(negedge pclk);
      t++;
    end while (frame_start_pulse !== 1'b1 && t < 5000);
    if (frame_start_pulse !== 1'b1) timeout();
  endtask
  task automatic count_pulses(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge pclk);
      if (frame_start_pulse === 1'b1) c++;
    end
  endtask
  task automatic shoot();
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic reset_values();
    logic [31:0] r;
    logic        e;
    rd_chk("ctrl", exposure_trigger_pkg::CTRL_OFS, 32'h0000_0103);
    rd_chk("raw", exposure_trigger_pkg::EXP_RAW_OFS, 32'h0000_0001);
    rd_chk("base", exposure_trigger_pkg::EXP_BASE_OFS, 32'h0000_0014);
    rd_chk("abs", exposure_trigger_pkg::EXP_ABS_OFS, 32'h0000_0014);
    rd_chk("period", exposure_trigger_pkg::FRAME_PER_OFS, 32'h0000_2710);
    apb(1'b0, 8'h1c, 32'h0000_0000, r, e);
    check("unmapped err", 32'h0000_0001, {31'h0000_0000, e});
  endtask
  task automatic raw_scn();
    wr(exposure_trigger_pkg::EXP_RAW_OFS, 32'h0000_0064);
    rd_chk("abs 100", exposure_trigger_pkg::EXP_ABS_OFS, 32'h0000_07d0);
    wr(exposure_trigger_pkg::EXP_RAW_OFS, 32'h0000_0000);
    rd_chk("raw 0", exposure_trigger_pkg::EXP_RAW_OFS, 32'h0000_0001);
    wr(exposure_trigger_pkg::EXP_RAW_OFS, 32'h0000_0fff);
    rd_chk("abs max", exposure_trigger_pkg::EXP_ABS_OFS, 32'h0001_3fec);
  endtask
  task automatic abs_scn();
    logic [31:0] vin[4] = '{32'h0000_007c, 32'h0000_0096, 32'h0000_009c, 32'h0000_0000};
    logic [31:0] vraw[4] = '{32'h0000_0002, 32'h0000_0002, 32'h0000_0003, 32'h0000_0001};
    wr(exposure_trigger_pkg::EXP_BASE_OFS, 32'h0000_003e);
    rd_chk("abs base", exposure_trigger_pkg::EXP_ABS_OFS, 32'h0003_dfc2);
    for (int i = 0; i < 4; i++) begin
      wr(exposure_trigger_pkg::EXP_ABS_OFS, vin[i]);
      rd_chk("raw from abs", exposure_trigger_pkg::EXP_RAW_OFS, vraw[i]);
      rd_chk("abs rounded", exposure_trigger_pkg::EXP_ABS_OFS, vraw[i] * 32'h0000_003e);
    end
  endtask
  task automatic legacy_scn();
    int t;
    int c;
    wr(exposure_trigger_pkg::EXP_BASE_OFS, 32'h0000_0014);
    wr(exposure_trigger_pkg::CTRL_OFS, 32'h0000_000f);
    wr(exposure_trigger_pkg::CMD_OFS, 32'h0000_0001);
    count_pulses(20, c);
    check("legacy idle", 32'h0000_0000, c);
    check("legacy wait as", 32'h0000_0000, {31'h0000_0000, wait_acq_start});
    check("legacy wait fs", 32'h0000_0001, {31'h0000_0000, wait_frame_start});
    shoot();
    wait_pulse(t);
    check_rng("edge delay", 1, 8, t);
    repeat (10) @(posedge pclk);
    shoot();
    count_pulses(300, c);
    check("ignored edge", 32'h0000_0000, c);
    wr(exposure_trigger_pkg::CTRL_OFS, 32'h0000_0007);
    wr(exposure_trigger_pkg::CMD_OFS, 32'h0000_0004);
    wait_pulse(t);
    check_rng("soft trigger", 1, 40, t);
    wr(exposure_trigger_pkg::CMD_OFS, 32'h0000_0002);
  endtask
  task automatic standard_scn();
    int t;
    int c;
    wr(exposure_trigger_pkg::EXP_RAW_OFS, 32'h0000_0002);
    wr(exposure_trigger_pkg::CTRL_OFS, 32'h0000_0062);
    wr(exposure_trigger_pkg::CMD_OFS, 32'h0000_0001);
    count_pulses(30, c);
    check("fs idle", 32'h0000_0000, c);
    check("fs wait as", 32'h0000_0000, {31'h0000_0000, wait_acq_start});
    check("fs wait fs", 32'h0000_0001, {31'h0000_0000, wait_frame_start});
    shoot();
    wait_pulse(t);
    check_rng("fs edge delay", 1, 8, t);
    c = 0;
    do begin
      c++;
      @(negedge pclk);
    end while (exposure_active === 1'b1 && c < 1000);
    check_rng("exposure length", 391, 400, c);
    wr(exposure_trigger_pkg::CMD_OFS, 32'h0000_0002);
  endtask
  task automatic free_scn();
    int t;
    wr(exposure_trigger_pkg::EXP_RAW_OFS, 32'h0000_0001);
    wr(exposure_trigger_pkg::FRAME_PER_OFS, 32'h0000_0064);
    wr(exposure_trigger_pkg::CTRL_OFS, 32'h0000_0102);
    wr(exposure_trigger_pkg::CMD_OFS, 32'h0000_0001);
    wait_pulse(t);
    wait_pulse(t);
    check_rng("rate interval", 990, 1030, t);
    wr(exposure_trigger_pkg::CTRL_OFS, 32'h0000_0002);
    wait_pulse(t);
    wait_pulse(t);
    check_rng("max rate interval", 192, 201, t);
    wr(exposure_trigger_pkg::CMD_OFS, 32'h0000_0002);
  endtask
  task automatic as_scn();
    int t;
    int c;
    wr(exposure_trigger_pkg::CTRL_OFS, 32'h0000_0004);
    wr(exposure_trigger_pkg::CMD_OFS, 32'h0000_0001);
    @(negedge pclk);
    check("as wait as", 32'h0000_0001, {31'h0000_0000, wait_acq_start});
    check("as wait fs", 32'h0000_0000, {31'h0000_0000, wait_frame_start});
    wr(exposure_trigger_pkg::CMD_OFS, 32'h0000_0004);
    wait_pulse(t);
    check_rng("as soft start", 1, 8, t);
    count_pulses(400, c);
    check("single frame", 32'h0000_0000, c);
    check("single idle", 32'h0000_0000, {30'h0000_0000, wait_acq_start, wait_frame_start});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    raw_scn();
    abs_scn();
    legacy_scn();
    standard_scn();
    free_scn();
    as_scn();
    end_sim();
  end
endmodule
